// File: verilog/aod_pkg.sv
package aod_pkg;
  // apb geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
  // field positions
  localparam int UPPER_LSB = 0;
  localparam int LOWER_LSB = 8;
  localparam int HOLD_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int FLAG_LSB = 0;
  // field widths
  localparam int THR_W = 8;
  localparam int HOLD_W = 3;
  localparam int MODE_W = 5;
  localparam int LEN_W = 4;
  localparam int NUM_FLAGS = 4;
  // values after reset
  localparam logic [THR_W-1:0] UPPER_RST = 8'hFF;
  localparam logic [THR_W-1:0] LOWER_RST = 8'hFF;
  localparam logic [HOLD_W-1:0] HOLD_RST = 3'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  // pin pulse length is 2^(HOLD_BASE_LOG2 + select) sampling-clock cycles
  localparam logic [LEN_W-1:0] HOLD_BASE_LOG2 = 4'h3;
  localparam logic [LEN_W-1:0] REAL_EXTRA_LOG2 = 4'h1;
  localparam int HOLD_MAX_CYCLES = 1024;
  // link modes
  localparam logic [MODE_W-1:0] MODE_REAL_DEC = 5'h09;
  localparam logic [MODE_W-1:0] MODE_CPLX_FIRST = 5'h0A;
  localparam logic [MODE_W-1:0] MODE_CPLX_LAST = 5'h10;
  localparam logic [MODE_W-1:0] MODE_CPLX_SKIP = 5'h0C;
  // flag vector order
  localparam int IDX_A_UPPER = 0;
  localparam int IDX_A_LOWER = 1;
  localparam int IDX_B_UPPER = 2;
  localparam int IDX_B_LOWER = 3;
endpackage

// File: verilog/aod_magnitude.sv
`timescale 1ns/10ps
module aod_magnitude #(
  parameter int SAMPLE_W = 12,
  parameter int CMP_W = 8
) (
  // sample in
  input wire logic [SAMPLE_W-1:0] sample_in,
  // compared magnitude out
  output logic [CMP_W-1:0] mag_out
);
  import aod_pkg::*;

  logic [SAMPLE_W-2:0] mag_full;

  if (CMP_W > SAMPLE_W - 1) begin : g_bad_width
    $error("compared width must not exceed magnitude width");
  end

  // the most negative code has no positive twin, so it saturates
  always_comb begin
    if (!sample_in[SAMPLE_W-1]) begin
      mag_full = sample_in[SAMPLE_W-2:0];
    end else if (sample_in[SAMPLE_W-2:0] == '0) begin
      mag_full = '1;
    end else begin
      mag_full = (SAMPLE_W-1)'(~sample_in + 1'b1);
    end
  end

  assign mag_out = mag_full[SAMPLE_W-2 -: CMP_W];
endmodule

// File: verilog/aod_stretch.sv
`timescale 1ns/10ps
module aod_stretch #(
  parameter int CNT_W = 11
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // event and length
  input wire logic hit_in,
  input wire logic [aod_pkg::LEN_W-1:0] len_log2_in,
  // stretched flag
  output logic flag_out
);
  import aod_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_flag;
  logic [CNT_W-1:0] len_m1;

  if ((1 << (CNT_W - 1)) < HOLD_MAX_CYCLES) begin : g_bad_cnt
    $error("counter too narrow for the longest pulse");
  end

  assign len_m1 = ~({CNT_W{1'b1}} << len_log2_in);

  // a new event restarts the count, so the length runs from the latest event
  always_comb begin
    next_cnt = cnt;
    next_flag = flag_out;
    if (hit_in) begin
      next_cnt = len_m1;
      next_flag = 1'b1;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end else begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= '0;
      flag_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      flag_out <= next_flag;
    end
  end
endmodule

// File: verilog/aod_top.sv
`timescale 1ns/10ps
module aod_top #(
  parameter int SAMPLE_W = 12,
  parameter int DEC_W = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [aod_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [aod_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [aod_pkg::STRB_W-1:0] pstrb_in,
  output logic [aod_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // converted samples, one per clock
  input wire logic [SAMPLE_W-1:0] chan_a_sample_in,
  input wire logic [SAMPLE_W-1:0] chan_b_sample_in,
  // decimated stream in
  input wire logic dec_valid_in,
  input wire logic dec_is_q_in,
  input wire logic [DEC_W-1:0] dec_a_data_in,
  input wire logic [DEC_W-1:0] dec_b_data_in,
  // decimated stream out
  output logic dec_valid_out,
  output logic [DEC_W-1:0] dec_a_data_out,
  output logic [DEC_W-1:0] dec_b_data_out,
  // overrange flag pins
  output logic chan_a_upper_flag_out,
  output logic chan_a_lower_flag_out,
  output logic chan_b_upper_flag_out,
  output logic chan_b_lower_flag_out
);
  import aod_pkg::*;

  if (SAMPLE_W != 12 || DEC_W < 2) begin : g_bad_params
    $error("sample width must be 12 and stream width at least 2");
  end

  function automatic logic is_complex(input logic [MODE_W-1:0] mode);
    return mode >= MODE_CPLX_FIRST && mode <= MODE_CPLX_LAST && mode != MODE_CPLX_SKIP;
  endfunction

  function automatic logic is_decimating(input logic [MODE_W-1:0] mode);
    return mode == MODE_REAL_DEC || is_complex(mode);
  endfunction

  logic [THR_W-1:0] upper_level_threshold;
  logic [THR_W-1:0] lower_level_threshold;
  logic [HOLD_W-1:0] hold_length_select;
  logic [MODE_W-1:0] link_mode_select;
  logic [THR_W-1:0] next_upper;
  logic [THR_W-1:0] next_lower;
  logic [HOLD_W-1:0] next_hold;
  logic [MODE_W-1:0] next_mode;
  logic wr_en;
  logic addr_ok;
  logic [THR_W-1:0] mag_a;
  logic [THR_W-1:0] mag_b;
  logic [NUM_FLAGS-1:0] hit;
  logic [NUM_FLAGS-1:0] pin_flag;
  logic [NUM_FLAGS-1:0] emb_flag;
  logic [LEN_W-1:0] pin_len;
  logic [LEN_W-1:0] emb_len;
  logic odd_sample;
  logic next_odd;
  logic next_dvalid;
  logic [DEC_W-1:0] next_a_data;
  logic [DEC_W-1:0] next_b_data;
  logic sel_a;
  logic sel_b;

  // zero wait states: every access completes in its first access cycle
  assign pready_out = 1'b1;
  assign addr_ok = paddr_in == ADDR_THRESH || paddr_in == ADDR_CONFIG ||
                   paddr_in == ADDR_STATUS;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign wr_en = psel_in && penable_in && pwrite_in;

  always_comb begin
    next_upper = upper_level_threshold;
    next_lower = lower_level_threshold;
    next_hold = hold_length_select;
    next_mode = link_mode_select;
    if (wr_en && paddr_in == ADDR_THRESH) begin
      if (pstrb_in[0]) begin
        next_upper = pwdata_in[UPPER_LSB +: THR_W];
      end
      if (pstrb_in[1]) begin
        next_lower = pwdata_in[LOWER_LSB +: THR_W];
      end
    end
    if (wr_en && paddr_in == ADDR_CONFIG) begin
      if (pstrb_in[0]) begin
        next_hold = pwdata_in[HOLD_LSB +: HOLD_W];
      end
      if (pstrb_in[1]) begin
        next_mode = pwdata_in[MODE_LSB +: MODE_W];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      upper_level_threshold <= UPPER_RST;
      lower_level_threshold <= LOWER_RST;
      hold_length_select <= HOLD_RST;
      link_mode_select <= MODE_RST;
    end else begin
      upper_level_threshold <= next_upper;
      lower_level_threshold <= next_lower;
      hold_length_select <= next_hold;
      link_mode_select <= next_mode;
    end
  end

  // read mux is combinational so the access needs no wait state
  always_comb begin
    prdata_out = '0;
    if (psel_in && !pwrite_in) begin
      if (paddr_in == ADDR_THRESH) begin
        prdata_out[UPPER_LSB +: THR_W] = upper_level_threshold;
        prdata_out[LOWER_LSB +: THR_W] = lower_level_threshold;
      end else if (paddr_in == ADDR_CONFIG) begin
        prdata_out[HOLD_LSB +: HOLD_W] = hold_length_select;
        prdata_out[MODE_LSB +: MODE_W] = link_mode_select;
      end else if (paddr_in == ADDR_STATUS) begin
        prdata_out[FLAG_LSB +: NUM_FLAGS] = pin_flag;
      end
    end
  end

  aod_magnitude #(.SAMPLE_W(SAMPLE_W), .CMP_W(THR_W)) u_mag_a (
    .sample_in(chan_a_sample_in),
    .mag_out(mag_a)
  );

  aod_magnitude #(.SAMPLE_W(SAMPLE_W), .CMP_W(THR_W)) u_mag_b (
    .sample_in(chan_b_sample_in),
    .mag_out(mag_b)
  );

  // one threshold pair shared by both channels
  assign hit[IDX_A_UPPER] = mag_a >= upper_level_threshold;
  assign hit[IDX_A_LOWER] = mag_a >= lower_level_threshold;
  assign hit[IDX_B_UPPER] = mag_b >= upper_level_threshold;
  assign hit[IDX_B_LOWER] = mag_b >= lower_level_threshold;

  assign pin_len = HOLD_BASE_LOG2 + LEN_W'(hold_length_select);
  assign emb_len = (link_mode_select == MODE_REAL_DEC) ?
                   REAL_EXTRA_LOG2 + LEN_W'(hold_length_select) :
                   LEN_W'(hold_length_select);

  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    aod_stretch #(.CNT_W(11)) u_pin (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .hit_in(hit[i]),
      .len_log2_in(pin_len),
      .flag_out(pin_flag[i])
    );
    aod_stretch #(.CNT_W(11)) u_emb (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .hit_in(hit[i]),
      .len_log2_in(emb_len),
      .flag_out(emb_flag[i])
    );
  end

  assign chan_a_upper_flag_out = pin_flag[IDX_A_UPPER];
  assign chan_a_lower_flag_out = pin_flag[IDX_A_LOWER];
  assign chan_b_upper_flag_out = pin_flag[IDX_B_UPPER];
  assign chan_b_lower_flag_out = pin_flag[IDX_B_LOWER];

  // real mode alternates even and odd samples; complex mode follows the I/Q tag
  always_comb begin
    next_odd = odd_sample;
    if (dec_valid_in) begin
      next_odd = !odd_sample;
    end
    if (is_complex(link_mode_select)) begin
      sel_a = dec_is_q_in ? emb_flag[IDX_A_LOWER] : emb_flag[IDX_A_UPPER];
      sel_b = dec_is_q_in ? emb_flag[IDX_B_LOWER] : emb_flag[IDX_B_UPPER];
    end else begin
      sel_a = odd_sample ? emb_flag[IDX_A_LOWER] : emb_flag[IDX_A_UPPER];
      sel_b = odd_sample ? emb_flag[IDX_B_LOWER] : emb_flag[IDX_B_UPPER];
    end
    next_dvalid = dec_valid_in;
    next_a_data = dec_a_data_out;
    next_b_data = dec_b_data_out;
    if (dec_valid_in) begin
      next_a_data = dec_a_data_in;
      next_b_data = dec_b_data_in;
      if (is_decimating(link_mode_select)) begin
        next_a_data = {dec_a_data_in[DEC_W-1:1], sel_a};
        next_b_data = {dec_b_data_in[DEC_W-1:1], sel_b};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      odd_sample <= 1'b0;
      dec_valid_out <= 1'b0;
      dec_a_data_out <= '0;
      dec_b_data_out <= '0;
    end else begin
      odd_sample <= next_odd;
      dec_valid_out <= next_dvalid;
      dec_a_data_out <= next_a_data;
      dec_b_data_out <= next_b_data;
    end
  end

  // checks
  logic emb_a_up;
  logic emb_a_lo;
  assign emb_a_up = emb_flag[IDX_A_UPPER];
  assign emb_a_lo = emb_flag[IDX_A_LOWER];

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_mag_saturate: assert property (
    chan_a_sample_in == 12'h800 |-> mag_a == 8'hFF)
    else $error("most negative sample did not saturate");
  a_mag_positive: assert property (
    !chan_b_sample_in[11] |-> mag_b == chan_b_sample_in[10:3])
    else $error("positive sample magnitude wrong");
  a_upper_sets_a: assert property (
    mag_a >= upper_level_threshold |=> chan_a_upper_flag_out)
    else $error("channel a upper flag missed");
  a_shared_thresh_b: assert property (
    mag_b >= upper_level_threshold |=> chan_b_upper_flag_out)
    else $error("channel b upper flag missed");
  a_lower_index_one: assert property (
    mag_a >= lower_level_threshold |=> chan_a_lower_flag_out)
    else $error("channel a lower flag missed");
  a_compare_top_bits: assert property (
    chan_a_sample_in[11] && chan_a_sample_in != 12'h800 |->
    mag_a == 8'((12'h000 - chan_a_sample_in) >> 3))
    else $error("negative sample magnitude wrong");
  a_hold_min_8: assert property (
    hit[IDX_A_UPPER] && hold_length_select == 3'h0 |=> chan_a_upper_flag_out [*8])
    else $error("shortest pulse under 8 cycles");
  a_hold_release_8: assert property (
    hit[IDX_A_UPPER] && hold_length_select == 3'h0 ##1 !hit[IDX_A_UPPER] [*8]
    |=> !chan_a_upper_flag_out)
    else $error("shortest pulse over 8 cycles");
  a_embed_pass: assert property (
    dec_valid_in && !is_decimating(link_mode_select) |=> dec_a_data_out == $past(dec_a_data_in))
    else $error("sample altered outside decimating modes");
  a_embed_iq: assert property (
    dec_valid_in && is_complex(link_mode_select) && dec_is_q_in |=>
    dec_a_data_out[0] == $past(emb_a_lo))
    else $error("q sample lsb is not the lower flag");
  a_embed_even: assert property (
    dec_valid_in && link_mode_select == MODE_REAL_DEC && !odd_sample |=>
    dec_a_data_out[0] == $past(emb_a_up))
    else $error("even sample lsb is not the upper flag");
  a_embed_period: assert property (
    is_complex(link_mode_select) && hold_length_select == 3'h0 && hit[IDX_A_UPPER]
    ##1 !hit[IDX_A_UPPER] |=> !emb_a_up)
    else $error("complex period of one sample overran");
  a_reset_clear: assert property (@(posedge core_clk_in) disable iff (1'b0)
    !nrst_in |-> pin_flag == '0 && emb_flag == '0)
    else $error("flags not clear in reset");

  c_upper_rise: cover property ($rose(chan_a_upper_flag_out));
  c_real_embed: cover property (dec_valid_in && link_mode_select == MODE_REAL_DEC && emb_a_up);
  c_cplx_embed: cover property (dec_valid_in && is_complex(link_mode_select) && dec_is_q_in);
  c_bad_addr: cover property (pslverr_out);
endmodule

// File: tb/aod_gain_ctrl.sv
`timescale 1ns/10ps
module aod_gain_ctrl #(
  parameter int QUIET_MAX = 255
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // flag pins
  input wire logic a_upper_in,
  input wire logic a_lower_in,
  input wire logic b_upper_in,
  input wire logic b_lower_in,
  // combined view and gain
  output logic upper_any_out,
  output logic lower_any_out,
  output logic [3:0] gain_out
);
  logic [7:0] quiet;
  assign upper_any_out = a_upper_in | b_upper_in;
  assign lower_any_out = a_lower_in | b_lower_in;
  // gain drops one unit a cycle, rises one unit per QUIET_MAX + 1 quiet cycles, and clamps at 0 and 15 so a long burst cannot wrap it
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gain_out <= 4'h8;
      quiet <= 8'h00;
    end else if (upper_any_out) begin
      gain_out <= (gain_out == 4'h0) ? 4'h0 : gain_out - 4'h1;
    end else if (lower_any_out) begin
      quiet <= 8'h00;
    end else if (quiet == 8'(QUIET_MAX)) begin
      gain_out <= (gain_out == 4'hF) ? 4'hF : gain_out + 4'h1;
      quiet <= 8'h00;
    end else begin
      quiet <= quiet + 8'h01;
    end
  end
endmodule

// File: tb/aod_top_tb_top.sv
`timescale 1ns/10ps
module aod_top_tb_top;
  import aod_pkg::*;
  logic core_clk_in = 1'b0;
  // starts high so the first drive low is a real falling edge
  logic nrst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [STRB_W-1:0] pstrb = '0;
  logic pready;
  logic pslverr;
  logic [11:0] smp_a = '0;
  logic [11:0] smp_b = '0;
  logic dv = 1'b0;
  logic dq = 1'b0;
  logic [15:0] dd = '0;
  logic [15:0] da;
  logic [15:0] db;
  logic dvo;
  logic fa_u, fa_l, fb_u, fb_l, any_l;
  logic [31:0] rd;
  logic er;
  logic [3:0] gain;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 core_clk_in = ~core_clk_in;

  aod_top u_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .chan_a_sample_in(smp_a), .chan_b_sample_in(smp_b), .dec_valid_in(dv),
    .dec_is_q_in(dq), .dec_a_data_in(dd), .dec_b_data_in(dd), .dec_valid_out(dvo),
    .dec_a_data_out(da), .dec_b_data_out(db), .chan_a_upper_flag_out(fa_u),
    .chan_a_lower_flag_out(fa_l), .chan_b_upper_flag_out(fb_u),
    .chan_b_lower_flag_out(fb_l));
  aod_gain_ctrl u_partner (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .a_upper_in(fa_u), .a_lower_in(fa_l), .b_upper_in(fb_u), .b_lower_in(fb_l),
    .upper_any_out(), .lower_any_out(any_l), .gain_out(gain));

  localparam logic [11:0] MAG_SMP [0:6] = '{12'h7FF, 12'h800, 12'h7F0, 12'h810,
    12'h7EF, 12'h811, 12'h000};

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // no bound on the wait; the run timeout catches a dead slave
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    smp_a <= '0;
    smp_b <= '0;
    nrst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_THRESH, 32'h0, 4'h0);
    check("thresh reset", rd, {16'h0, LOWER_RST, UPPER_RST});
    apb(1'b0, ADDR_CONFIG, 32'h0, 4'h0);
    check("config reset", rd, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
    check("status reset", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, 4'h0);
    check("unmapped error", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_THRESH, 32'h12345678, 4'h2);
    apb(1'b0, ADDR_THRESH, 32'h0, 4'h0);
    check("strobe lane", rd, 32'h000056FF);
    apb(1'b1, ADDR_STATUS, 32'hF, 4'hF);
    apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
    check("status read only", rd, 32'h0);
  endtask

  // 254 vs 255 thresholds split the full-scale codes 7FF and saturated 800 from 7F0 and 810
  task automatic t_mag();
    apb(1'b1, ADDR_THRESH, 32'h0000FFFE, 4'hF);
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk_in);
      smp_a <= MAG_SMP[i];
      @(posedge core_clk_in);
      smp_a <= '0;
      @(posedge core_clk_in);
      check("a upper flag", fa_u, i < 4);
      check("a lower flag", fa_l, i < 2);
      repeat (10) @(posedge core_clk_in);
    end
  endtask

  task automatic t_hold();
    int n;
    int m;
    apb(1'b1, ADDR_THRESH, 32'h000040E4, 4'hF);
    for (int h = 0; h < 8; h++) begin
      apb(1'b1, ADDR_CONFIG, h, 4'hF);
      @(posedge core_clk_in);
      smp_b <= 12'h200;
      @(posedge core_clk_in);
      smp_b <= '0;
      n = 0;
      m = 0;
      repeat ((8 << h) + 8) begin
        @(posedge core_clk_in);
        if (fb_l === 1'b1) n++;
        if ((fa_u | fa_l | fb_u) !== 1'b0) m++;
        if (n == 1 && fb_l === 1'b1) check("receiver or", any_l, 1'b1);
      end
      check("pulse length", n, 8 << h);
      check("other flags", m, 0);
    end
  endtask

  task automatic emb(input logic q, input logic [15:0] ea, input logic [15:0] eb);
    @(posedge core_clk_in);
    dv <= 1'b1;
    dq <= q;
    dd <= 16'h5A5A;
    @(posedge core_clk_in);
    dv <= 1'b0;
    @(posedge core_clk_in);
    check("stream valid", dvo, 1'b1);
    check("stream a", da, ea);
    check("stream b", db, eb);
  endtask

  task automatic t_stream();
    do_reset();
    @(posedge core_clk_in);
    check("flags after reset", {fa_u, fa_l, fb_u, fb_l}, 4'h0);
    apb(1'b1, ADDR_THRESH, 32'h000040E4, 4'hF);
    apb(1'b1, ADDR_CONFIG, {19'h0, MODE_REAL_DEC, 8'h00}, 4'hF);
    smp_a <= 12'h7FF;
    smp_b <= 12'h200;
    repeat (40) @(posedge core_clk_in);
    check("gain cut", gain, 4'h0);
    emb(1'b0, 16'h5A5B, 16'h5A5A);
    emb(1'b0, 16'h5A5B, 16'h5A5B);
    for (int m = 10; m < 17; m++) begin
      apb(1'b1, ADDR_CONFIG, m << 8, 4'hF);
      repeat (4) @(posedge core_clk_in);
      if (m == 12) begin
        emb(1'b0, 16'h5A5A, 16'h5A5A);
      end else begin
        emb(1'b0, 16'h5A5B, 16'h5A5A);
        emb(1'b1, 16'h5A5B, 16'h5A5B);
      end
    end
    apb(1'b1, ADDR_CONFIG, 32'h0, 4'hF);
    emb(1'b0, 16'h5A5A, 16'h5A5A);
    // one hit, then the real-mode period of 4 cycles for hold 1 must still show it
    smp_a <= '0;
    apb(1'b1, ADDR_CONFIG, {19'h0, MODE_REAL_DEC, 8'h01}, 4'hF);
    repeat (8) @(posedge core_clk_in);
    smp_a <= 12'h7FF;
    @(posedge core_clk_in);
    smp_a <= '0;
    repeat (2) @(posedge core_clk_in);
    emb(1'b0, 16'h5A5B, 16'h5A5A);
    emb(1'b0, 16'h5A5A, 16'h5A5B);
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    do_reset();
    t_regs();
    t_mag();
    t_hold();
    t_stream();
    results();
  end
endmodule
